// [design/mt8_map.svh]
/*
 * constants of the 8-bit modulo timer: register offsets, field positions,
 * reset values and prescaler limits.
 * assumes inclusion by bare name from design files; holds definitions only.
 */
`ifndef MT8_MAP_SVH
`define MT8_MAP_SVH

// ----------------------------------------------------------------------
// register offsets on the 4-bit register port
// ----------------------------------------------------------------------
`define MT8_OFS_STATUS   4'h0
`define MT8_OFS_CLOCK    4'h1
`define MT8_OFS_COUNT    4'h2
`define MT8_OFS_LIMIT    4'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MT8_SC_FLAG      7
`define MT8_SC_IRQEN     6
`define MT8_SC_CLEAR     5
`define MT8_SC_HALT      4
`define MT8_CK_SRC_HI    5
`define MT8_CK_SRC_LO    4
`define MT8_CK_PS_HI     3
`define MT8_CK_PS_LO     0

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define MT8_HALT_RST     1'b1
`define MT8_IRQEN_RST    1'b0
`define MT8_FLAG_RST     1'b0
`define MT8_PS_RST       4'h0
`define MT8_COUNT_RST    8'h00
`define MT8_LIMIT_RST    8'h00
`define MT8_LIMIT_FREE   8'h00
`define MT8_FREE_TOP     8'hff
`define MT8_DIV_RST      8'h00
`define MT8_PS_MAX       4'h8
`define MT8_RDATA_RST    8'h00
`define MT8_SYNC_RST     3'h0

`endif

// [design/mt8_pkg.sv]
/*
 * types of the 8-bit modulo timer.
 * assumes nothing of its surroundings.
 */
package mt8_pkg;

    // clock source codes of the clock configuration register
    typedef enum logic [1:0] {
        mt8_src_bus   = 2'h0,
        mt8_src_fixed = 2'h1,
        mt8_src_fall  = 2'h2,
        mt8_src_rise  = 2'h3
    } mt8_src_e;

endpackage : mt8_pkg

// [design/mt8_tick_if.sv]
/*
 * tick carrier between the timer core and its prescaler.
 * assumes both ends run on the one bus clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface mt8_tick_if;
    logic       src_tick;   // one tick of the selected source
    logic       clear;      // restart of the divider
    logic [3:0] prescale;   // tap select
    logic       out_tick;   // divided tick

    modport core (output src_tick, output clear, output prescale, input out_tick);
    modport pre  (input src_tick, input clear, input prescale, output out_tick);
endinterface : mt8_tick_if

`default_nettype wire

// [design/mt8_prescaler.sv]
/*
 * nine-tap prescaler: divides source ticks by 1 to 256.
 * assumes src_tick is a one-cycle pulse on the bus clock.
 */
`timescale 1ns/100ps
`default_nettype none

`include "mt8_map.svh"

module mt8_prescaler
    import mt8_pkg::*;
(
    // clock and reset
    input  wire logic  clock_i,
    input  wire logic  nrst_i,
    // tick carrier
    mt8_tick_if.pre    tick
);

    logic [7:0] div_reg;
    logic [3:0] tap;
    logic [7:0] mask;

    // codes above the last tap fall back to divide by 256 [R3]
    always_comb begin
        tap  = (tick.prescale > `MT8_PS_MAX) ? `MT8_PS_MAX : tick.prescale;
        mask = 8'((9'h001 << tap) - 9'h001);
    end

    // a tick passes when all selected low divider bits are ones [R3]
    assign tick.out_tick = tick.src_tick && (&(div_reg | ~mask));

    // divider restarts with the count so the first tick is a full period [R23]
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_reg <= `MT8_DIV_RST;
        end else if (tick.clear) begin
            div_reg <= `MT8_DIV_RST;
        end else if (tick.src_tick) begin
            div_reg <= div_reg + 8'h01;
        end
    end

endmodule : mt8_prescaler

`default_nettype wire

// [design/mt8_top.sv]
/*
 * 8-bit modulo timer: register port, source select, counter, overflow flag.
 * assumes a single-cycle strobe register master on the bus clock; the two
 * external clock inputs are asynchronous and run below a quarter of it.
 */
// Summary of operation
// (R1) source field picks bus, fixed, pin fall, rise
// (R2) source change keeps the running count
// (R3) prescale codes divide 1 to 256, above clamp
// (R4) prescale change keeps the running count
// (R5) clock config bits 7:6 read zero
// (R6) reset: halted, zero count, zero limit, defaults
// (R7) count reads current value, writes ignored
// (R8) zero limit means free-running full wrap
// (R9) limit write zeroes count and clears flag
// (R10) count increments per tick, wraps after limit
// (R11) flag sets on limit to zero transition
// (R12) flag clears after read-while-set then write zero
// (R13) overflow between read and write keeps flag
// (R14) clear command also clears flag at once
// (R15) irq request equals flag and enable
// (R16) software clears flag before enabling irq
// (R17) software starts free-running by clearing halt
// (R18) halt freezes count, reset sets halt
// (R19) clear command zeroes count, reads zero
// (R20) pin synchronised, kept below quarter bus rate
// (R21) debug mode suspends counting, then resumes
// (R22) selected pin edge gives one-cycle tick
// (R23) divider restarts with count on restarts
`timescale 1ns/100ps
`default_nettype none

`include "mt8_map.svh"

module mt8_top
    import mt8_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // clock inputs from outside the bus clock domain
    input  wire logic       fixed_freq_clock_i,
    input  wire logic       external_timer_clock_pin_i,
    // processor in active background debug
    input  wire logic       debug_halt_i,
    // overflow interrupt request
    output logic            overflow_irq_o
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic       counter_halt_reg;
    logic       overflow_irq_enable_reg;
    logic       overflow_flag_reg;
    logic       clear_armed_reg;
    mt8_src_e   clock_source_select_reg;
    logic [3:0] prescale_select_reg;
    logic [7:0] count_value_reg;
    logic [7:0] wrap_limit_reg;
    logic [7:0] rdata_reg;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic wr_status;
    logic wr_clock;
    logic wr_limit;
    logic rd_status;
    logic restart;
    logic running;
    logic tick_run;
    logic ovf_evt;
    logic [7:0] top_value;

    // write strobes for status, clock and limit, a read strobe for status; unmapped offsets do nothing
    always_comb begin
        wr_status = 1'b0;
        wr_clock  = 1'b0;
        wr_limit  = 1'b0;
        rd_status = rd_i && (addr_i == `MT8_OFS_STATUS);
        if (wr_i && addr_i == `MT8_OFS_STATUS) begin
            wr_status = 1'b1;
        end else if (wr_i && addr_i == `MT8_OFS_CLOCK) begin
            wr_clock = 1'b1;
        end else if (wr_i && addr_i == `MT8_OFS_LIMIT) begin
            wr_limit = 1'b1;
        end
    end

    // restart by clear command or limit write [R9] [R19]
    assign restart = wr_limit || (wr_status && wdata_i[`MT8_SC_CLEAR]);

    // ------------------------------------------------------------------
    // synchronisers and edge detect
    // ------------------------------------------------------------------
    logic [2:0] pin_sync_reg;
    logic [2:0] fix_sync_reg;
    logic       pin_rise;
    logic       pin_fall;
    logic       fix_rise;

    // two flops before use, a third only for edge compare [R20]
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_sync_reg <= `MT8_SYNC_RST;
            fix_sync_reg <= `MT8_SYNC_RST;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], external_timer_clock_pin_i};
            fix_sync_reg <= {fix_sync_reg[1:0], fixed_freq_clock_i};
        end
    end

    // one-cycle pulse per qualifying edge [R22]
    assign pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
    assign pin_fall = !pin_sync_reg[1] && pin_sync_reg[2];
    assign fix_rise = fix_sync_reg[1] && !fix_sync_reg[2];

    // ------------------------------------------------------------------
    // source select and prescaler
    // ------------------------------------------------------------------
    mt8_tick_if tick_bus ();
    logic src_tick;

    // source mux; the count is untouched by a change [R1] [R2]
    always_comb begin
        case (clock_source_select_reg)
            mt8_src_bus:   src_tick = 1'b1;
            mt8_src_fixed: src_tick = fix_rise;
            mt8_src_fall:  src_tick = pin_fall;
            mt8_src_rise:  src_tick = pin_rise;
            default:       src_tick = 1'b1;
        endcase
    end

    // halt and debug also freeze the divider, so no tick is half spent [R18] [R21]
    assign running           = !counter_halt_reg && !debug_halt_i;
    assign tick_bus.src_tick = src_tick && running;
    assign tick_bus.clear    = restart;            // [R23]
    assign tick_bus.prescale = prescale_select_reg; // [R4]

    mt8_prescaler u_prescaler (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .tick    (tick_bus)
    );

    assign tick_run = tick_bus.out_tick;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // a zero limit wraps at the full range [R8]
    assign top_value = (wrap_limit_reg == `MT8_LIMIT_FREE) ? `MT8_FREE_TOP
                                                           : wrap_limit_reg;
    // a restart in the same cycle wins, so no overflow then
    assign ovf_evt   = tick_run && !restart && (count_value_reg == top_value); // [R11]

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_value_reg <= `MT8_COUNT_RST;                // [R6]
        end else if (restart) begin
            count_value_reg <= `MT8_COUNT_RST;                // [R9] [R19]
        end else if (ovf_evt) begin
            count_value_reg <= `MT8_COUNT_RST;                // [R10]
        end else if (tick_run) begin
            count_value_reg <= count_value_reg + 8'h01;       // [R10]
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // halt, irq enable; clear command is write-only and not stored [R18] [R19]
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            counter_halt_reg        <= `MT8_HALT_RST;         // [R6] [R18]
            overflow_irq_enable_reg <= `MT8_IRQEN_RST;
        end else if (wr_status) begin
            counter_halt_reg        <= wdata_i[`MT8_SC_HALT];
            overflow_irq_enable_reg <= wdata_i[`MT8_SC_IRQEN];
        end
    end

    // clock configuration; bits 7:6 are not stored [R5]
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clock_source_select_reg <= mt8_src_bus;           // [R6]
            prescale_select_reg     <= `MT8_PS_RST;
        end else if (wr_clock) begin
            clock_source_select_reg <= mt8_src_e'(wdata_i[`MT8_CK_SRC_HI:`MT8_CK_SRC_LO]);
            prescale_select_reg     <= wdata_i[`MT8_CK_PS_HI:`MT8_CK_PS_LO];
        end
    end

    // limit; count register has no write path at all [R7]
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wrap_limit_reg <= `MT8_LIMIT_RST;                 // [R6]
        end else if (wr_limit) begin
            wrap_limit_reg <= wdata_i;                        // [R9]
        end
    end

    // ------------------------------------------------------------------
    // overflow flag with two-step clear
    // ------------------------------------------------------------------
    // arming: a status read while the flag is set; any overflow or
    // status write disarms, so a second overflow is never lost [R12] [R13]
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clear_armed_reg <= 1'b0;
        end else if (ovf_evt || wr_status || wr_limit) begin
            clear_armed_reg <= 1'b0;                          // [R13]
        end else if (rd_status && overflow_flag_reg) begin
            clear_armed_reg <= 1'b1;                          // [R12]
        end
    end

    // set wins over the two-step clear; a restart in the same cycle blocks the set and clears
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overflow_flag_reg <= `MT8_FLAG_RST;
        end else if (ovf_evt) begin
            overflow_flag_reg <= 1'b1;                        // [R11]
        end else if (restart) begin
            overflow_flag_reg <= 1'b0;                        // [R9] [R14]
        end else if (wr_status && clear_armed_reg && !wdata_i[`MT8_SC_FLAG]) begin
            overflow_flag_reg <= 1'b0;                        // [R12]
        end
    end

    // software must clear the flag before enabling, else irq fires at once [R16]
    assign overflow_irq_o = overflow_flag_reg && overflow_irq_enable_reg; // [R15]

    // ------------------------------------------------------------------
    // read data, one cycle after the read strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= `MT8_RDATA_RST;
        end else if (!rd_i) begin
            rdata_reg <= `MT8_RDATA_RST;
        end else if (addr_i == `MT8_OFS_STATUS) begin
            // clear command reads zero [R19]
            rdata_reg <= {overflow_flag_reg, overflow_irq_enable_reg, 1'b0,
                          counter_halt_reg, 4'h0};
        end else if (addr_i == `MT8_OFS_CLOCK) begin
            rdata_reg <= {2'b00, clock_source_select_reg, prescale_select_reg}; // [R5]
        end else if (addr_i == `MT8_OFS_COUNT) begin
            rdata_reg <= count_value_reg;                     // [R7]
        end else if (addr_i == `MT8_OFS_LIMIT) begin
            rdata_reg <= wrap_limit_reg;
        end else begin
            rdata_reg <= `MT8_RDATA_RST;
        end
    end

    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    cfg_zero_a: assert property ( // [R5]
        rd_i && addr_i == `MT8_OFS_CLOCK |=> rdata_o[7:6] == 2'b00)
        else $error("clock config top bits not zero");

    cnt_ro_a: assert property ( // [R7]
        wr_i && addr_i == `MT8_OFS_COUNT && !tick_run
        |=> $stable(count_value_reg))
        else $error("count changed by a write");

    lim_wr_a: assert property ( // [R9]
        wr_limit |=> count_value_reg == 8'h00 && !overflow_flag_reg)
        else $error("limit write did not restart");

    wrap_a: assert property ( // [R11]
        tick_run && !restart && count_value_reg == top_value
        |=> count_value_reg == 8'h00 && overflow_flag_reg)
        else $error("no wrap with flag at limit");

    inc_a: assert property ( // [R10]
        tick_run && !restart && count_value_reg != top_value
        |=> count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("count did not advance");

    free_run_a: assert property ( // [R8]
        wrap_limit_reg == 8'h00 && tick_run && !restart
        && count_value_reg == 8'hfe |=> count_value_reg == 8'hff)
        else $error("free-running mode wrapped early");

    halt_hold_a: assert property ( // [R18]
        (counter_halt_reg || debug_halt_i) && !restart |=> $stable(count_value_reg))
        else $error("count moved while halted");

    cmd_clear_a: assert property ( // [R14]
        wr_status && wdata_i[`MT8_SC_CLEAR]
        |=> count_value_reg == 8'h00 && !overflow_flag_reg)
        else $error("clear command ignored");

    two_step_a: assert property ( // [R12]
        (rd_status && overflow_flag_reg && !ovf_evt && !wr_i)
        ##1 (!ovf_evt && !wr_i)
        ##1 (wr_status && !wdata_i[`MT8_SC_FLAG] && !ovf_evt) |=> !overflow_flag_reg)
        else $error("two-step clear failed");

    keep_flag_a: assert property ( // [R13]
        overflow_flag_reg && wr_status && !clear_armed_reg && !restart
        |=> overflow_flag_reg)
        else $error("flag cleared without arming");

    irq_a: assert property ( // [R15]
        ovf_evt && overflow_irq_enable_reg && !wr_status |=> overflow_irq_o)
        else $error("no irq request after overflow");

    edge_a: assert property ( // [R22]
        clock_source_select_reg == mt8_src_rise && src_tick
        |=> !src_tick || clock_source_select_reg != mt8_src_rise)
        else $error("pin edge gave more than one tick");

endmodule : mt8_top

`default_nettype wire

// [bench/mt8_top_tb.sv]
/*
 * self-checking bench of the 8-bit modulo timer: register port tasks,
 * reset values, prescale taps, modulo wrap, flag clearing, irq, debug
 * freeze and the three non-bus clock sources.
 * assumes the design files and mt8_map.svh are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

`include "mt8_map.svh"

// one comparison: counted, reported at once on mismatch
`define CHK(nm, ex, got) \
    begin \
        compares++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
        end \
    end

module mt8_top_tb;
    import mt8_pkg::*;

    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    logic       clock_i;
    logic       nrst_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       fixed_clk;
    logic       pin;
    logic       debug_halt;
    logic       irq;
    int         failures;
    int         compares;
    logic [7:0] a_val;
    logic [7:0] b_val;
    logic [7:0] d_val;
    int         div;

    mt8_top i_dut (
        .clock_i                    (clock_i),
        .nrst_i                     (nrst_i),
        .addr_i                     (addr_i),
        .wdata_i                    (wdata_i),
        .wr_i                       (wr_i),
        .rd_i                       (rd_i),
        .rdata_o                    (rdata_o),
        .fixed_freq_clock_i         (fixed_clk),
        .external_timer_clock_pin_i (pin),
        .debug_halt_i               (debug_halt),
        .overflow_irq_o             (irq)
    );

    // bus clock 250 MHz
    always #2 clock_i = ~clock_i;

    // fixed clock at bus/8, well inside the quarter-rate limit of the synchroniser
    always begin
        repeat (4) @(posedge clock_i);
        fixed_clk <= ~fixed_clk;
    end

    // ------------------------------------------------------------------
    // register port tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe edge, so look just after it
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    // two count reads whose strobe edges lie g+2 cycles apart
    task automatic delta(input int g);
        rd(`MT8_OFS_COUNT, a_val);
        repeat (g) @(posedge clock_i);
        rd(`MT8_OFS_COUNT, b_val);
        d_val = b_val - a_val;
    endtask : delta

    // pin toggles at bus/8, then time for the synchroniser to settle
    task automatic toggle_pin(input int n);
        repeat (n) begin
            repeat (4) @(posedge clock_i);
            pin <= ~pin;
        end
        repeat (8) @(posedge clock_i);
    endtask : toggle_pin

    task automatic test_done(input string nm);
        $display("test %s finished", nm);
    endtask : test_done

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // watchdog: the tests need about 12k cycles
    // ------------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clock_i);
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clock_i    = 1'b0;
        nrst_i     = 1'b0;
        addr_i     = 4'h0;
        wdata_i    = 8'h00;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        fixed_clk  = 1'b0;
        pin        = 1'b0;
        debug_halt = 1'b0;
        failures   = 0;
        compares   = 0;
        repeat (3) @(posedge clock_i);
        nrst_i <= 1'b1;

        // reset values, reserved bits, read-only count, unmapped places
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("status rst", 8'h10, d_val)
        rd(`MT8_OFS_CLOCK, d_val);
        `CHK("clock rst", 8'h00, d_val)
        rd(`MT8_OFS_LIMIT, d_val);
        `CHK("limit rst", 8'h00, d_val)
        rd(4'h9, d_val);
        `CHK("unmapped", 8'h00, d_val)
        wr(`MT8_OFS_CLOCK, 8'hff);
        rd(`MT8_OFS_CLOCK, d_val);
        `CHK("clock hi", 8'h3f, d_val)
        wr(`MT8_OFS_COUNT, 8'h55);
        wr(4'h9, 8'hff);
        wr(`MT8_OFS_CLOCK, 8'h00);
        delta(10);
        `CHK("halted cnt", 8'h00, b_val)
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("status kept", 8'h10, d_val)
        test_done("reset");

        // free running from reset, every prescale code; change never clears
        wr(`MT8_OFS_STATUS, 8'h00);
        for (int c = 0; c < 16; c++) begin
            rd(`MT8_OFS_COUNT, b_val);
            wr(`MT8_OFS_CLOCK, 8'(c));
            rd(`MT8_OFS_COUNT, a_val);
            `CHK("ps keep", 1'b1, (8'(a_val - b_val) <= 8'h04))
            rd(`MT8_OFS_CLOCK, d_val);
            `CHK("ps read", 8'(c), d_val)
            div = (c > 8) ? 256 : (1 << c);
            delta(div * 5 - 2);
            `CHK("ps rate", 8'h05, d_val)
        end
        // slow taps leave the count far from the top, so run the full range at divide by 1
        wr(`MT8_OFS_CLOCK, 8'h00);
        repeat (260) @(posedge clock_i);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("free flag", 8'h80, d_val)
        test_done("prescale");

        // modulo wrap; overflow between arming read and write keeps flag
        wr(`MT8_OFS_CLOCK, 8'h00);
        wr(`MT8_OFS_LIMIT, 8'h05);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("limit clr", 8'h00, d_val)
        delta(6);
        `CHK("wrap", 8'((a_val + 8) % 6), b_val)
        wr(`MT8_OFS_LIMIT, 8'h01);
        // odd phase: arming read and clearing write straddle exactly one overflow
        repeat (5) @(posedge clock_i);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("flag set", 8'h80, d_val)
        wr(`MT8_OFS_STATUS, 8'h00);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("clr cancel", 8'h80, d_val)
        wr(`MT8_OFS_STATUS, 8'h10);
        wr(`MT8_OFS_STATUS, 8'h10);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("no arm", 8'h90, d_val)
        wr(`MT8_OFS_STATUS, 8'h10);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("two step", 8'h10, d_val)
        test_done("modulo");

        // irq enabled only with flag clear, then clear command
        wr(`MT8_OFS_STATUS, 8'h50);
        repeat (2) @(posedge clock_i);
        #1;
        `CHK("irq off", 1'b0, irq)
        wr(`MT8_OFS_LIMIT, 8'h03);
        wr(`MT8_OFS_STATUS, 8'h40);
        repeat (10) @(posedge clock_i);
        #1;
        `CHK("irq on", 1'b1, irq)
        wr(`MT8_OFS_STATUS, 8'h70);
        rd(`MT8_OFS_STATUS, d_val);
        `CHK("clr cmd", 8'h50, d_val)
        `CHK("irq drop", 1'b0, irq)
        rd(`MT8_OFS_COUNT, d_val);
        `CHK("clr cnt", 8'h00, d_val)
        test_done("irq");

        // debug freeze and resume
        wr(`MT8_OFS_LIMIT, 8'h00);
        wr(`MT8_OFS_STATUS, 8'h00);
        @(posedge clock_i);
        debug_halt <= 1'b1;
        delta(10);
        `CHK("dbg hold", 8'h00, d_val)
        @(posedge clock_i);
        debug_halt <= 1'b0;
        delta(10);
        `CHK("dbg run", 8'h0c, d_val)
        test_done("debug");

        // pin rising, pin falling, fixed clock; switching keeps the count
        rd(`MT8_OFS_COUNT, b_val);
        wr(`MT8_OFS_CLOCK, 8'h30);
        rd(`MT8_OFS_COUNT, a_val);
        `CHK("src keep", 1'b1, (8'(a_val - b_val) <= 8'h04))
        toggle_pin(7);
        rd(`MT8_OFS_COUNT, b_val);
        `CHK("pin rise", 8'h04, 8'(b_val - a_val))
        wr(`MT8_OFS_CLOCK, 8'h20);
        rd(`MT8_OFS_COUNT, a_val);
        toggle_pin(7);
        rd(`MT8_OFS_COUNT, b_val);
        `CHK("pin fall", 8'h04, 8'(b_val - a_val))
        wr(`MT8_OFS_CLOCK, 8'h10);
        delta(38);
        `CHK("fixed src", 8'h05, d_val)
        test_done("sources");

        end_of_test();
    end

endmodule : mt8_top_tb

`default_nettype wire
